// ### isc_defines.svh
// constants for the interrupt status collector: offsets, bit positions, timing
// assumes a 32-bit AXI4-Lite register bus and a 10 MHz device clock
`ifndef ISC_DEFINES_SVH
`define ISC_DEFINES_SVH

// ============================================================
// register byte offsets
`define ISC_OFS_CONFIG      8'h54
`define ISC_OFS_STATUS      8'h58
`define ISC_OFS_ENABLE      8'h5C
`define ISC_OFS_BYTE_TEST   8'h64
`define ISC_OFS_ID          8'h50
`define ISC_ADDR_MSB        7
// ============================================================
// status bit positions
`define ISC_BIT_SOFT        31
`define ISC_BIT_TX_HALT     25
`define ISC_BIT_RX_HALT     24
`define ISC_BIT_DROP_MID    23
`define ISC_BIT_TX_DONE     21
`define ISC_BIT_RX_DMA      20
`define ISC_BIT_TIMER       19
`define ISC_BIT_PHY         18
`define ISC_BIT_POWER       17
`define ISC_BIT_TSO         16
`define ISC_BIT_RWT         15
`define ISC_BIT_RXE         14
`define ISC_BIT_TXE         13
`define ISC_BIT_TX_DATA_OVERRUN_FLAG        10
`define ISC_BIT_TX_SPACE_AVAILABLE_FLAG        9
`define ISC_BIT_TX_STATUS_FULL_FLAG        8
`define ISC_BIT_TX_STATUS_LEVEL_FLAG        7
`define ISC_BIT_RXDF        6
`define ISC_BIT_RX_STATUS_FULL_FLAG        4
`define ISC_BIT_RX_STATUS_LEVEL_FLAG        3
// ============================================================
// masks and reset values
`define ISC_STATUS_MASK     32'h83BF_E7DF
`define ISC_WC_MASK         32'h83BB_E7DF
`define ISC_ZERO32          32'h0000_0000
`define ISC_BYTE_TEST_VAL   32'h8765_4321
`define ISC_ID_VAL          32'h1234_0000
// config register fields
`define ISC_CFG_HOLD_MSB    31
`define ISC_CFG_HOLD_LSB    24
`define ISC_CFG_MASTER      12
// ============================================================
// timing: holdoff unit of 10 us at 100 ns per clock
`define ISC_HOLD_UNIT_NS    10000
`define ISC_CLK_NS          100
`define ISC_HOLD_UNIT_CYC   ((`ISC_HOLD_UNIT_NS) / (`ISC_CLK_NS))
`define ISC_DROP_MID_OLD    32'h7FFF_FFFF
`define ISC_DROP_MID_NEW    32'h8000_0000
`define ISC_TIMER_WRAP      16'hFFFF
`define ISC_PIN_W           3
`define ISC_RESP_OKAY       2'h0
`define ISC_RESP_SLVERR     2'h2

`endif

// ### isc_pkg.sv
// types for the interrupt status collector
// assumes isc_defines.svh is on the include path
package isc_pkg;
  // ============================================================
  // per-cycle event pulses from the source units
  typedef struct packed {
    logic       tx_halted;
    logic       rx_halted;
    logic       tx_buffer_done;
    logic       rx_dma_done;
    logic       tx_status_overflow;
    logic       rx_watchdog;
    logic       rx_error;
    logic       tx_error;
    logic       tx_data_overrun;
    logic       tx_space_available;
    logic       tx_status_full;
    logic       tx_status_level;
    logic       frame_dropped;
    logic       rx_status_full;
    logic       rx_status_level;
    logic       power_event;
  } isc_event_type;
  // dropped-frame counter and timer value as seen each cycle
  typedef struct packed {
    logic [31:0] drop_count;
    logic [15:0] timer_count;
  } isc_count_type;
  typedef enum logic [1:0] {
    ISC_WR_IDLE = 2'b00,
    ISC_WR_RESP = 2'b01
  } isc_wr_state_type;
endpackage

// ### isc_top.sv
// interrupt status collector: sticky event flags, write-one clear, mask, holdoff
// assumes source pulses are synchronous to aclk; gpio pins and phy level are async
//
// How it works
// - 32-bit status at 58h; writing one clears a flag, zero keeps it.
// - bit 31 sets when software raises soft_event_enable.
// - bit 25 sets when a requested transmit stop has halted the transmitter.
// - bit 24 sets when the receiver halts.
// - bit 23 sets when drop counter steps 7FFFFFFFh to 80000000h.
// - bit 21 sets when a marked transmit buffer finished loading.
// - bit 20 sets when the receive DMA dword count is read out.
// - bit 19 sets when the timer wraps through zero to FFFFh.
// - bit 18 is read-only, follows the phy, writes ignored.
// - bit 17 sets on power event regardless of wake pin; write one clears.
// - power event does not wake; any write to byte test wakes.
// - power event bypasses the interrupt holdoff interval.
// - bit 16 sets on transmit status FIFO overflow.
// - bit 15 sets on receive watchdog, packet over 2048 bytes.
// - bit 14 receive error, bit 13 transmit error.
// - bit 10 sets on write to a full transmit data FIFO.
// - bit 9 sets when transmit free space exceeds threshold.
// - bit 8 transmit status full, bit 4 receive status full.
// - bit 7 transmit status level, bit 3 receive status level.
// - bit 6 sets whenever a receive frame is dropped.
// - bits 2-0 capture gpio pin events, cleared by writing one.
// - flags record events regardless of the enable mask.
// - master line high whenever an enabled flag is active.
// - holdoff interval counts in 10 microsecond units.
`timescale 1ns/1ps
`include "isc_defines.svh"

module isc_top (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write address, data and response
  input  wire logic [31:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // event sources
  input  wire isc_pkg::isc_event_type    events,
  input  wire isc_pkg::isc_count_type    counts,
  input  wire logic                      phy_event_level,
  input  wire logic [`ISC_PIN_W-1:0]     pin_events,
  // outputs to the pin logic and power control
  output logic                           master_irq,
  output logic                           irq_request,
  output logic                           wake_request
);
  import isc_pkg::*;

  // ============================================================
  // state
  logic [31:0]            event_status;
  logic [31:0]            enable_mask;
  logic                   soft_event_enable;
  logic [7:0]             holdoff_interval;
  logic [7:0]             hold_units;
  logic [15:0]            hold_cycles;
  logic                   asleep;
  logic [`ISC_PIN_W-1:0]  pin_sync1;
  logic [`ISC_PIN_W-1:0]  pin_sync2;
  logic [`ISC_PIN_W-1:0]  pin_prev;
  logic [`ISC_PIN_W-1:0]  pin_edge;
  logic                   phy_sync1;
  logic                   phy_sync2;
  logic [31:0]            drop_prev;
  logic [15:0]            timer_prev;
  logic                   soft_prev;
  isc_wr_state_type       wr_state;
  logic                   aw_held;
  logic                   w_held;
  logic [7:0]             aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic [31:0]            next_set;
  logic [31:0]            wr_mask;
  logic                   wr_fire;
  logic [31:0]            pending;

  // ============================================================
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync1 <= '0;
      pin_sync2 <= '0;
      phy_sync1 <= 1'b0;
      phy_sync2 <= 1'b0;
    end else begin
      pin_sync1 <= pin_events;
      pin_sync2 <= pin_sync1;
      phy_sync1 <= phy_event_level;
      phy_sync2 <= phy_sync1;
    end
  end

  // previous values for edge and crossing detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev   <= '0;
      drop_prev  <= `ISC_ZERO32;
      timer_prev <= `ISC_TIMER_WRAP;
      soft_prev  <= 1'b0;
    end else begin
      pin_prev   <= pin_sync2;
      drop_prev  <= counts.drop_count;
      timer_prev <= counts.timer_count;
      soft_prev  <= soft_event_enable;
    end
  end

  // ============================================================
  // write channel: take address and data in either order
  assign wr_fire = aw_held && w_held && (wr_state == ISC_WR_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= `ISC_ZERO32;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      // ready is a one-cycle pulse so each beat is taken once
      s_axi_awready <= !aw_held && s_axi_awvalid && !s_axi_awready;
      s_axi_wready  <= !w_held && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[`ISC_ADDR_MSB:0];
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response follows both beats
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state     <= ISC_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ISC_RESP_OKAY;
    end else begin
      case (wr_state)
        ISC_WR_IDLE: begin
          if (wr_fire) begin
            wr_state     <= ISC_WR_RESP;
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
              `ISC_OFS_CONFIG, `ISC_OFS_STATUS, `ISC_OFS_ENABLE,
              `ISC_OFS_BYTE_TEST, `ISC_OFS_ID: s_axi_bresp <= `ISC_RESP_OKAY;
              default: s_axi_bresp <= `ISC_RESP_SLVERR;
            endcase
          end
        end
        ISC_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state     <= ISC_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state     <= ISC_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // byte-lane mask of the accepted write data
  always_comb begin
    wr_mask = `ISC_ZERO32;
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) begin
        wr_mask[b*8 +: 8] = w_data[b*8 +: 8];
      end
    end
  end

  // ============================================================
  // configuration registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_mask       <= `ISC_ZERO32;
      soft_event_enable <= 1'b0;
      holdoff_interval  <= 8'h00;
    end else if (wr_fire && aw_addr == `ISC_OFS_ENABLE) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b]) begin
          // reserved positions never become enabled
          enable_mask[b*8 +: 8] <= 8'((w_data & `ISC_STATUS_MASK) >> (b*8));
        end
      end
      if (w_strb[3]) begin
        soft_event_enable <= w_data[`ISC_BIT_SOFT];
      end
    end else if (wr_fire && aw_addr == `ISC_OFS_CONFIG && w_strb[3]) begin
      holdoff_interval <= w_data[`ISC_CFG_HOLD_MSB:`ISC_CFG_HOLD_LSB];
    end
  end

  // ============================================================
  // event set terms, one per flag
  always_comb begin
    next_set = `ISC_ZERO32;
    next_set[`ISC_BIT_SOFT]     = soft_event_enable && !soft_prev;
    next_set[`ISC_BIT_TX_HALT]  = events.tx_halted;
    next_set[`ISC_BIT_RX_HALT]  = events.rx_halted;
    next_set[`ISC_BIT_DROP_MID] = (drop_prev == `ISC_DROP_MID_OLD)
                                  && (counts.drop_count == `ISC_DROP_MID_NEW);
    next_set[`ISC_BIT_TX_DONE]  = events.tx_buffer_done;
    next_set[`ISC_BIT_RX_DMA]   = events.rx_dma_done;
    next_set[`ISC_BIT_TIMER]    = (timer_prev == 16'h0000)
                                  && (counts.timer_count == `ISC_TIMER_WRAP);
    // power event, independent of wake pin
    next_set[`ISC_BIT_POWER]    = events.power_event;
    next_set[`ISC_BIT_TSO]      = events.tx_status_overflow;
    next_set[`ISC_BIT_RWT]      = events.rx_watchdog;
    next_set[`ISC_BIT_RXE]      = events.rx_error;
    next_set[`ISC_BIT_TXE]      = events.tx_error;
    next_set[`ISC_BIT_TX_DATA_OVERRUN_FLAG]     = events.tx_data_overrun;
    next_set[`ISC_BIT_TX_SPACE_AVAILABLE_FLAG]     = events.tx_space_available;
    next_set[`ISC_BIT_TX_STATUS_FULL_FLAG]     = events.tx_status_full;
    next_set[`ISC_BIT_RX_STATUS_FULL_FLAG]     = events.rx_status_full;
    next_set[`ISC_BIT_TX_STATUS_LEVEL_FLAG]     = events.tx_status_level;
    next_set[`ISC_BIT_RX_STATUS_LEVEL_FLAG]     = events.rx_status_level;
    next_set[`ISC_BIT_RXDF]     = events.frame_dropped;
  end

  // gpio rising edges, one per pin
  genvar g;
  generate
    for (g = 0; g < `ISC_PIN_W; g++) begin : gen_pin
      assign pin_edge[g] = pin_sync2[g] && !pin_prev[g];
    end
  endgenerate

  // ============================================================
  // sticky flags; set beats clear, mask never gates capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_status <= `ISC_ZERO32;
    end else begin
      // write one clears, set wins, unmasked capture
      event_status <= ((event_status & ~((wr_fire && aw_addr == `ISC_OFS_STATUS)
                       ? (wr_mask & `ISC_WC_MASK) : `ISC_ZERO32))
                       | next_set
                       | 32'(pin_edge))
                       & `ISC_STATUS_MASK;
      // phy bit only follows its source
      event_status[`ISC_BIT_PHY] <= phy_sync2;
    end
  end

  // ============================================================
  // master line, holdoff and delivered request
  assign pending = event_status & enable_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_irq <= 1'b0;
    end else begin
      // any enabled flag raises the master line
      master_irq <= |pending;
    end
  end

  // holdoff counter: reloads after each delivered request drops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_units  <= 8'h00;
      hold_cycles <= 16'h0000;
    end else if (holdoff_interval == 8'h00) begin
      hold_units  <= 8'h00;
      hold_cycles <= 16'h0000;
    end else if (irq_request && !(|pending)) begin
      hold_units  <= holdoff_interval;
      hold_cycles <= 16'(`ISC_HOLD_UNIT_CYC - 1);
    end else if (hold_units != 8'h00) begin
      if (hold_cycles == 16'h0000) begin
        hold_units  <= hold_units - 8'h01;
        hold_cycles <= 16'(`ISC_HOLD_UNIT_CYC - 1);
      end else begin
        hold_cycles <= hold_cycles - 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= (|pending && hold_units == 8'h00)
                     || pending[`ISC_BIT_POWER];
    end
  end

  // ============================================================
  // sleep: only a byte-test write wakes the device
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      asleep       <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      // power event never wakes; byte-test write does
      wake_request <= wr_fire && aw_addr == `ISC_OFS_BYTE_TEST && asleep;
      if (events.power_event) begin
        asleep <= 1'b1;
      end
      if (wr_fire && aw_addr == `ISC_OFS_BYTE_TEST) begin
        asleep <= 1'b0;
      end
    end
  end

  // ============================================================
  // read channel; one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `ISC_ZERO32;
      s_axi_rresp   <= `ISC_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `ISC_RESP_OKAY;
        case (s_axi_araddr[`ISC_ADDR_MSB:0])
          `ISC_OFS_STATUS:    s_axi_rdata <= event_status;
          `ISC_OFS_ENABLE:    s_axi_rdata <= enable_mask;
          `ISC_OFS_CONFIG:    s_axi_rdata <= {holdoff_interval, 11'h0, master_irq, 12'h0};
          `ISC_OFS_BYTE_TEST: s_axi_rdata <= `ISC_BYTE_TEST_VAL;
          `ISC_OFS_ID:        s_axi_rdata <= `ISC_ID_VAL;  // arbitrary id value
          default: begin
            s_axi_rdata <= `ISC_ZERO32;
            s_axi_rresp <= `ISC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ============================================================
  // assertions
  sequence seq_clear_write;
    wr_fire && aw_addr == `ISC_OFS_STATUS;
  endsequence

  AST_W1C_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_clear_write ##0 (wr_mask[`ISC_BIT_RXE] && !next_set[`ISC_BIT_RXE])
    |=> !event_status[`ISC_BIT_RXE])
    else $error("status bit not cleared by write one");
  AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
    next_set[`ISC_BIT_TXE] |=> event_status[`ISC_BIT_TXE])
    else $error("event lost against clear");
  AST_RESERVED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    (event_status & ~`ISC_STATUS_MASK) == `ISC_ZERO32)
    else $error("reserved status bit set");
  AST_PHY_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn)
    event_status[`ISC_BIT_PHY] == $past(phy_sync2))
    else $error("phy bit does not follow source");
  AST_MASTER: assert property (@(posedge aclk) disable iff (!aresetn)
    (|pending) |=> master_irq)
    else $error("master line missed pending flag");
  AST_POWER_BYPASS: assert property (@(posedge aclk) disable iff (!aresetn)
    pending[`ISC_BIT_POWER] |=> irq_request)
    else $error("power event delayed by holdoff");
  AST_WAKE_ONLY_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_request |-> $past(wr_fire) && $past(aw_addr) == `ISC_OFS_BYTE_TEST)
    else $error("wake without byte test write");
  AST_TIMER_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    (timer_prev == 16'h0000 && counts.timer_count == `ISC_TIMER_WRAP)
    |=> event_status[`ISC_BIT_TIMER])
    else $error("timer wrap not captured");
endmodule // isc_top

// ### isc_host_model.sv
// host model: an axi4-lite master that issues one access at a time
// assumes the slave answers on its own schedule; every wait is bounded
`timescale 1ns/1ps

module isc_host_model (
  // clock
  input  wire logic        aclk,
  // write channels
  output logic [31:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // read channels
  output logic [31:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  localparam int LIMIT = 64; // cycles allowed for any answer

  // ============================================================
  // idle levels from time zero
  initial begin
    {awaddr, wdata, araddr} = {3{32'h0000_0000}};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    wstrb = 4'hF; // whole words only
  end

  // ============================================================
  // write: address and data offered together, bready held until answered
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r,
                    output bit ok);
    int n;
    n = 0;
    ok = 0;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!ok && n < LIMIT) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        ok = 1;
      end
    end
  endtask

  // ============================================================
  // read: rready held until rvalid is sampled high
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r,
                    output bit ok);
    int n;
    n = 0;
    ok = 0;
    d = 32'h0000_0000;
    r = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ok && n < LIMIT) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        ok = 1;
      end
    end
  endtask
endmodule // isc_host_model

// ### isc_testbench.sv
// testbench for the interrupt status collector: register sequences with expected values
// assumes isc_defines.svh on the include path; the host model drives the bus
`timescale 1ns/1ps
`include "isc_defines.svh"

module testbench;
  import isc_pkg::*;
  logic            aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready, master_irq, irq_request, wake_request;
  logic [31:0]     awaddr, wdata, araddr, rdata, d;
  logic [3:0]      wstrb;
  logic [1:0]      bresp, rresp, r;
  logic [2:0]      pin_events;
  logic            phy_event_level, wake_seen;
  isc_event_type   events;
  isc_count_type   counts;
  bit              ok;
  int              fails, samples_checked;
  // status bit reached by each event field, lsb field first
  int bitpos [16] = '{17, 3, 4, 6, 7, 8, 9, 10, 13, 14, 15, 16, 20, 21, 24, 25};

  // ============================================================
  // clock and wake pulse catcher; the pulse is one cycle, so keep it sticky
  initial aclk = 1'b0;
  always #50 aclk = ~aclk;
  always @(posedge aclk) if (wake_request === 1'b1) wake_seen <= 1'b1;

  isc_host_model host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  isc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .events(events),
    .counts(counts), .phy_event_level(phy_event_level), .pin_events(pin_events),
    .master_irq(master_irq), .irq_request(irq_request), .wake_request(wake_request));

  // ============================================================
  // shared tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    host_u.wr(a, v, r, ok);
    chk({31'h0, ok}, 32'h1, "write answered");
    if (!ok) stop_test();
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
    host_u.rd(a, d, r, ok);
    chk({31'h0, ok}, 32'h1, "read answered");
    if (!ok) stop_test();
    chk(d, exp, what);
  endtask

  // one-cycle event pulse, driven just after an edge
  task automatic pulse(input logic [15:0] m);
    @(posedge aclk);
    events <= isc_event_type'(m);
    @(posedge aclk);
    events <= isc_event_type'(16'h0000);
  endtask

  // hang guard: a run that overstays counts as a mismatch
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    stop_test();
  end

  // ============================================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    events = isc_event_type'(16'h0000);
    counts = isc_count_type'(48'h0);
    {phy_event_level, pin_events, wake_seen} = 5'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`ISC_OFS_STATUS, `ISC_ZERO32, "status after reset");
    // each source sets only its own flag, mask left at zero
    for (int k = 0; k < 16; k++) begin
      pulse(16'h0001 << k);
      rdc(`ISC_OFS_STATUS, 32'h1 << bitpos[k], "flag set");
      wr(`ISC_OFS_STATUS, 32'h0000_0000);
      rdc(`ISC_OFS_STATUS, 32'h1 << bitpos[k], "zero write keeps");
      wr(`ISC_OFS_STATUS, 32'h1 << bitpos[k]);
      rdc(`ISC_OFS_STATUS, 32'h0, "one write clears");
    end
    // power event put the device to sleep; only a byte-test write wakes it
    chk({31'h0, wake_seen}, 32'h0, "no wake from power event");
    wr(`ISC_OFS_BYTE_TEST, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    chk({31'h0, wake_seen}, 32'h1, "wake on byte test write");
    @(posedge aclk);
    counts <= {`ISC_DROP_MID_OLD, 16'h0001};
    @(posedge aclk);
    counts <= {`ISC_DROP_MID_NEW, 16'h0000};
    @(posedge aclk);
    counts <= {32'h8000_0001, `ISC_TIMER_WRAP};
    rdc(`ISC_OFS_STATUS, 32'h0088_0000, "midpoint and wrap");
    wr(`ISC_OFS_STATUS, 32'h0088_0000);
    // transceiver flag ignores writes and follows its source
    phy_event_level <= 1'b1;
    repeat (6) @(posedge aclk);
    wr(`ISC_OFS_STATUS, 32'h0004_0000);
    rdc(`ISC_OFS_STATUS, 32'h0004_0000, "phy flag read only");
    phy_event_level <= 1'b0;
    repeat (6) @(posedge aclk);
    rdc(`ISC_OFS_STATUS, 32'h0, "phy flag follows");
    // pin events latch on rising edges only
    pin_events <= 3'h5;
    repeat (6) @(posedge aclk);
    rdc(`ISC_OFS_STATUS, 32'h0000_0005, "pin flags");
    wr(`ISC_OFS_STATUS, 32'h0000_0005);
    rdc(`ISC_OFS_STATUS, 32'h0, "pin flags cleared while high");
    pin_events <= 3'h0;
    wr(`ISC_OFS_ENABLE, 32'h8000_0000);
    rdc(`ISC_OFS_STATUS, 32'h8000_0000, "soft flag");
    chk({31'h0, master_irq}, 32'h1, "master on");
    wr(`ISC_OFS_STATUS, 32'h8000_0000);
    repeat (2) @(posedge aclk);
    chk({31'h0, master_irq}, 32'h0, "master off");
    // all sources at once, reserved bits stay zero
    pulse(16'hFFFF);
    rdc(`ISC_OFS_STATUS, 32'h0333_E7D8, "all sources");
    wr(`ISC_OFS_STATUS, 32'hFFFF_FFFF);
    rdc(`ISC_OFS_STATUS, 32'h0, "reserved read zero");
    host_u.rd(32'h0000_0000, d, r, ok);
    chk({30'h0, r}, {30'h0, `ISC_RESP_SLVERR}, "unmapped refused");
    // one 100-cycle holdoff unit delays a request after one drops
    wr(`ISC_OFS_CONFIG, 32'h0100_0000);
    wr(`ISC_OFS_ENABLE, 32'h0002_4000);
    pulse(16'h0200);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_request}, 32'h1, "request without holdoff");
    wr(`ISC_OFS_STATUS, 32'h0000_4000);
    pulse(16'h0200);
    repeat (80) @(posedge aclk);
    chk({31'h0, irq_request}, 32'h0, "request held off");
    repeat (25) @(posedge aclk);
    chk({31'h0, irq_request}, 32'h1, "request after holdoff");
    // power event is delivered inside a running holdoff
    wr(`ISC_OFS_STATUS, 32'h0000_4000);
    pulse(16'h0001);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_request}, 32'h1, "power bypasses holdoff");
    stop_test();
  end
endmodule // testbench
